// ---- tlp_pkg.sv ----
// Constants and carrier types for the transceiver loopback and pattern test block
package tlp_pkg;

   // Word and window widths
   localparam int WMAX      = 10;
   localparam int AWIN      = 16;
   localparam int HLEN      = 23;
   localparam int W8        = 8;
   localparam int W10       = 10;

   // Test pattern selection
   typedef enum logic [2:0] {
      TLP_PAT_OFF    = 3'h0,
      TLP_PAT_PRBS7  = 3'h1,
      TLP_PAT_PRBS8  = 3'h2,
      TLP_PAT_PRBS10 = 3'h3,
      TLP_PAT_PRBS23 = 3'h4,
      TLP_PAT_HF     = 3'h5
   } tlp_pat_t;

   // Word aligner states, Gray coded
   typedef enum logic [1:0] {
      TLP_AL_HUNT = 2'h0,
      TLP_AL_LOCK = 2'h1
   } tlp_al_t;

   // Power state that allows the reverse parallel loopback
   localparam logic [1:0]  TLP_PWR_P0       = 2'h0;

   // Word alignment patterns, first serial bit in bit 0
   localparam logic [15:0] TLP_ALN_PRBS7    = 16'h3040;
   localparam logic [15:0] TLP_ALN_PRBS8    = 16'hFF5A;
   localparam logic [15:0] TLP_ALN_PRBS10   = 16'h03FF;
   localparam logic [15:0] TLP_ALN_PRBS23   = 16'hFFFF;
   localparam logic [4:0]  TLP_ALN_LEN16    = 5'h10;
   localparam logic [4:0]  TLP_ALN_LEN10    = 5'h0A;

   // Alternating high-frequency word, 1 sent first
   localparam logic [9:0]  TLP_HF_WORD      = 10'h155;

   // Generator seed and verifier fill count
   localparam logic [22:0] TLP_SEED         = 23'h7FFFFF;
   localparam logic [4:0]  TLP_FILL_BITS    = 5'h17;

   // Control from fabric logic, same clock
   typedef struct packed {
      logic       pipe_mode;
      logic       loop_req;
      logic [1:0] power_state;
      logic       serial_loop;
      tlp_pat_t   pattern;
      logic       width10;
      logic       verify_en;
   } tlp_ctrl_t;

   // Status to fabric logic
   typedef struct packed {
      logic rev_loop_active;
      logic ser_loop_active;
      logic aligned;
      logic pattern_ok;
      logic prbs_locked;
      logic prbs_error;
   } tlp_stat_t;

   // Result of walking a PRBS history through one word
   typedef struct packed {
      logic [22:0] hist;
      logic [9:0]  word;
      logic        err;
   } tlp_walk_t;

endpackage

// ---- tlp_channel.sv ----
// Transceiver channel test logic: loopbacks, pattern generator and PRBS verifier
`timescale 1ns/10ps

module tlp_channel #(
   parameter logic [15:0] DATA_ALIGN     = 16'h017C,
   parameter logic [4:0]  DATA_ALIGN_LEN = 5'h0A
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire tlp_pkg::tlp_ctrl_t        ctrl,
   input  wire logic [tlp_pkg::WMAX-1:0]  tx_data,
   output logic                           tx_ready,
   output logic [tlp_pkg::WMAX-1:0]       rx_data,
   output logic                           rx_valid,
   output tlp_pkg::tlp_stat_t             stat,
   output logic                           ser_tx_bit,
   input  wire logic                      ser_rx_bit,
   output logic                           rx_buf_en
);
   import tlp_pkg::*;

   // Feedback bit from history, newest bit in bit 0
   function automatic logic prbs_fb(logic [HLEN-1:0] h, tlp_pat_t p);
      case (p)
         TLP_PAT_PRBS7:  prbs_fb = h[6] ^ h[5];
         TLP_PAT_PRBS8:  prbs_fb = h[7] ^ h[6];
         TLP_PAT_PRBS10: prbs_fb = h[9] ^ h[6];
         TLP_PAT_PRBS23: prbs_fb = h[22] ^ h[17];
         default:        prbs_fb = 1'b0;
      endcase
   endfunction

   // Walk one word through the history; generate or check against data
   function automatic tlp_walk_t prbs_walk(logic [HLEN-1:0] h, tlp_pat_t p, logic w10,
                                           logic [WMAX-1:0] d, logic gen);
      tlp_walk_t r;
      logic      b;
      r.hist = h;
      r.word = '0;
      r.err  = 1'b0;
      for (int i = 0; i < WMAX; i++) begin
         if (w10 || i < W8) begin
            b = prbs_fb(r.hist, p);
            if (!gen && d[i] != b) begin
               r.err = 1'b1;
            end
            if (!gen) begin
               b = d[i];
            end
            r.word[i] = b;
            r.hist    = {r.hist[HLEN-2:0], b};
         end
      end
      return r;
   endfunction

   // Width support of each pattern
   function automatic logic pat_ok(tlp_pat_t p, logic w10);
      case (p)
         TLP_PAT_PRBS7, TLP_PAT_PRBS8, TLP_PAT_PRBS23: pat_ok = !w10;
         TLP_PAT_PRBS10:                               pat_ok = w10;
         default:                                      pat_ok = 1'b1;
      endcase
   endfunction

   function automatic logic is_prbs(tlp_pat_t p);
      is_prbs = (p == TLP_PAT_PRBS7) || (p == TLP_PAT_PRBS8) ||
                (p == TLP_PAT_PRBS10) || (p == TLP_PAT_PRBS23);
   endfunction

   // Alignment pattern for the selected pattern
   function automatic logic [15:0] aln_pat(tlp_pat_t p);
      case (p)
         TLP_PAT_PRBS7:  aln_pat = TLP_ALN_PRBS7;
         TLP_PAT_PRBS8:  aln_pat = TLP_ALN_PRBS8;
         TLP_PAT_PRBS10: aln_pat = TLP_ALN_PRBS10;
         TLP_PAT_PRBS23: aln_pat = TLP_ALN_PRBS23;
         default:        aln_pat = DATA_ALIGN;
      endcase
   endfunction

   function automatic logic [4:0] aln_len(tlp_pat_t p);
      case (p)
         TLP_PAT_PRBS10:                               aln_len = TLP_ALN_LEN10;
         TLP_PAT_PRBS7, TLP_PAT_PRBS8, TLP_PAT_PRBS23: aln_len = TLP_ALN_LEN16;
         default:                                      aln_len = DATA_ALIGN_LEN;
      endcase
   endfunction

   // Mode decode
   logic       rev_act;
   logic       ser_act;
   logic       pat_good;
   logic [3:0] wlast;
   assign rev_act  = ctrl.pipe_mode && ctrl.loop_req &&
                     (ctrl.power_state == TLP_PWR_P0);
   assign ser_act  = !ctrl.pipe_mode && ctrl.serial_loop;
   assign pat_good = pat_ok(ctrl.pattern, ctrl.width10);
   assign wlast    = ctrl.width10 ? 4'(W10 - 1) : 4'(W8 - 1);
   assign rx_buf_en = !ser_act;

   // Transmit state: serializer, generator history
   logic [3:0]      tx_cnt,  next_tx_cnt;
   logic [WMAX-1:0] tx_sh,   next_tx_sh;
   logic [HLEN-1:0] gen_h,   next_gen_h;
   logic            tx_load;
   tlp_walk_t       gen_w;
   logic [1:0]      pre_cnt, next_pre_cnt;
   logic [1:0]      pre_words;
   logic [15:0]     gen_aln;
   logic [WMAX-1:0] pre_word;

   // Receive side: pin sync, loop retime, aligner
   logic [1:0]      pin_sync;
   logic [1:0]      loop_rt;
   logic            rx_bit;
   logic [AWIN-1:0] rwin,    next_rwin;
   logic [WMAX-1:0] dsh,     next_dsh;
   logic [3:0]      rx_cnt,  next_rx_cnt;
   tlp_al_t         al_st,   next_al_st;
   logic            word_stb;
   logic [WMAX-1:0] word_al;
   logic [15:0]     win_bits;
   logic            pat_hit;

   // Rate match stage, fabric outputs, verifier
   logic [WMAX-1:0] rm_word, next_rm_word;
   logic            rm_valid, next_rm_valid;
   logic [WMAX-1:0] next_rx_data;
   logic            next_rx_valid;
   logic [HLEN-1:0] chk_h,   next_chk_h;
   logic [4:0]      chk_fill, next_chk_fill;
   logic            chk_err, next_chk_err;
   tlp_walk_t       chk_w;

   assign tx_load = (tx_cnt == wlast);
   assign gen_w   = prbs_walk(gen_h, ctrl.pattern, ctrl.width10, '0, 1'b1);
   // Alignment words lead the PRBS stream; some patterns never occur inside the sequence
   assign gen_aln   = aln_pat(ctrl.pattern);
   assign pre_words = ctrl.width10 ? 2'h1 : 2'h2;
   assign pre_word  = ctrl.width10 ? gen_aln[WMAX-1:0] :
                      {2'h0, (pre_cnt[0] ? gen_aln[15:8] : gen_aln[7:0])};

   // Serializer load and shift; source picked by loopback and pattern
   always_comb begin
      next_tx_cnt = tx_load ? 4'h0 : tx_cnt + 4'h1;
      next_tx_sh  = {1'b0, tx_sh[WMAX-1:1]};
      next_gen_h  = gen_h;
      next_pre_cnt = pre_cnt;
      tx_ready    = 1'b0;
      if (tx_load) begin
         if (rev_act) begin
            next_tx_sh = rm_word;
         end else if (ctrl.pattern == TLP_PAT_HF) begin
            next_tx_sh = TLP_HF_WORD;
         end else if (is_prbs(ctrl.pattern) && pat_good) begin
            if (pre_cnt < pre_words) begin
               next_tx_sh   = pre_word;
               next_pre_cnt = pre_cnt + 2'h1;
            end else begin
               next_tx_sh = gen_w.word;
               next_gen_h = gen_w.hist;
            end
         end else begin
            next_tx_sh = tx_data;
            tx_ready   = !is_prbs(ctrl.pattern);
         end
         if (!ctrl.width10) begin
            next_tx_sh[WMAX-1:W8] = '0;
         end
      end
      if (!is_prbs(ctrl.pattern) || !pat_good) begin
         next_pre_cnt = 2'h0;
      end
   end

   // Transmit registers; the generator is reseeded only by reset, so the sequence wraps by itself
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_cnt <= 4'h0;
         tx_sh  <= '0;
         gen_h  <= TLP_SEED;
         pre_cnt <= 2'h0;
      end else begin
         tx_cnt <= next_tx_cnt;
         tx_sh  <= next_tx_sh;
         gen_h  <= next_gen_h;
         pre_cnt <= next_pre_cnt;
      end
   end

   // Transmit pin keeps running in every loopback
   assign ser_tx_bit = tx_sh[0];

   // Pin synchroniser and loopback retiming pair
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_sync <= 2'h0;
         loop_rt  <= 2'h0;
      end else begin
         pin_sync <= {pin_sync[0], ser_rx_bit};
         loop_rt  <= {loop_rt[0], tx_sh[0]};
      end
   end

   // Input buffer bypassed while serial loopback runs
   assign rx_bit   = ser_act ? loop_rt[1] : pin_sync[1];
   assign win_bits = next_rwin >> (5'(AWIN) - aln_len(ctrl.pattern));
   assign pat_hit  = (win_bits == (aln_pat(ctrl.pattern) &
                      ((16'h0001 << aln_len(ctrl.pattern)) - 16'h0001)));

   // Deserializer and word aligner
   always_comb begin
      next_rwin   = {rx_bit, rwin[AWIN-1:1]};
      next_dsh    = {rx_bit, dsh[WMAX-1:1]};
      next_rx_cnt = (rx_cnt == wlast) ? 4'h0 : rx_cnt + 4'h1;
      next_al_st  = al_st;
      word_stb    = 1'b0;
      word_al     = ctrl.width10 ? next_dsh : (next_dsh >> (W10 - W8));
      case (al_st)
         TLP_AL_HUNT: begin
            if (ctrl.pattern == TLP_PAT_HF) begin
               next_al_st = TLP_AL_LOCK;
            end else if (pat_hit) begin
               next_al_st  = TLP_AL_LOCK;
               next_rx_cnt = 4'h0;
            end
         end
         TLP_AL_LOCK: begin
            word_stb = (rx_cnt == wlast);
         end
         default: begin
            next_al_st = TLP_AL_HUNT;
         end
      endcase
   end

   // Aligner registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rwin   <= '0;
         dsh    <= '0;
         rx_cnt <= 4'h0;
         al_st  <= TLP_AL_HUNT;
      end else begin
         rwin   <= next_rwin;
         dsh    <= next_dsh;
         rx_cnt <= next_rx_cnt;
         al_st  <= next_al_st;
      end
   end

   assign chk_w = prbs_walk(chk_h, ctrl.pattern, ctrl.width10, word_al, 1'b0);

   // Rate match stage, fabric delivery and PRBS verifier
   always_comb begin
      next_rm_word  = rm_word;
      next_rm_valid = word_stb;
      next_rx_data  = rx_data;
      next_rx_valid = rm_valid;
      next_chk_h    = chk_h;
      next_chk_fill = chk_fill;
      next_chk_err  = chk_err;
      if (word_stb) begin
         next_rm_word = word_al;
      end
      if (rm_valid) begin
         next_rx_data = rm_word;
      end
      if (!ctrl.verify_en || !is_prbs(ctrl.pattern)) begin
         next_chk_fill = 5'h00;
         next_chk_err  = 1'b0;
      end else if (word_stb) begin
         next_chk_h = chk_w.hist;
         if (chk_fill >= TLP_FILL_BITS) begin
            next_chk_err = chk_err | chk_w.err;
         end else begin
            next_chk_fill = chk_fill + (ctrl.width10 ? 5'(W10) : 5'(W8));
         end
      end
   end

   // Receive output and verifier registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rm_word  <= '0;
         rm_valid <= 1'b0;
         rx_data  <= '0;
         rx_valid <= 1'b0;
         chk_h    <= '0;
         chk_fill <= 5'h00;
         chk_err  <= 1'b0;
      end else begin
         rm_word  <= next_rm_word;
         rm_valid <= next_rm_valid;
         rx_data  <= next_rx_data;
         rx_valid <= next_rx_valid;
         chk_h    <= next_chk_h;
         chk_fill <= next_chk_fill;
         chk_err  <= next_chk_err;
      end
   end

   // Status
   assign stat.rev_loop_active = rev_act;
   assign stat.ser_loop_active = ser_act;
   assign stat.aligned         = (al_st == TLP_AL_LOCK);
   assign stat.pattern_ok      = pat_good;
   assign stat.prbs_locked     = (chk_fill >= TLP_FILL_BITS);
   assign stat.prbs_error      = chk_err;

endmodule

// ---- tlp_channel_asserts.sv ----
// Port checker for the channel test block
`timescale 1ns/10ps
module tlp_channel_asserts (
   input wire logic                      clk_sys,
   input wire logic                      rst,
   input wire tlp_pkg::tlp_ctrl_t        ctrl,
   input wire logic [tlp_pkg::WMAX-1:0]  tx_data,
   input wire logic                      tx_ready,
   input wire logic [tlp_pkg::WMAX-1:0]  rx_data,
   input wire logic                      rx_valid,
   input wire tlp_pkg::tlp_stat_t        stat,
   input wire logic                      ser_tx_bit,
   input wire logic                      ser_rx_bit,
   input wire logic                      rx_buf_en
);
   import tlp_pkg::*;
   // Expected legality of the selected pattern at this width
   wire logic w8_only = ctrl.pattern inside {TLP_PAT_PRBS7, TLP_PAT_PRBS8, TLP_PAT_PRBS23};
   wire logic ok_exp  = w8_only ? !ctrl.width10 : (ctrl.pattern != TLP_PAT_PRBS10 || ctrl.width10);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A received word is followed by a quiet stretch
   sequence s_quiet;
      !rx_valid [*7];
   endsequence
   // Verifier locked with unchanged control
   sequence s_hold;
      ctrl.verify_en && stat.prbs_locked && $stable(ctrl);
   endsequence
   a_rev_gate: assert property (
      stat.rev_loop_active == (ctrl.pipe_mode && ctrl.loop_req && ctrl.power_state == TLP_PWR_P0))
      else $error("reverse loopback gate wrong");
   a_ser_gate: assert property (
      stat.ser_loop_active == (!ctrl.pipe_mode && ctrl.serial_loop))
      else $error("serial loopback gate wrong");
   a_buf_off: assert property (rx_buf_en == !stat.ser_loop_active)
      else $error("input buffer enable wrong");
   a_pat_legal: assert property (
      ctrl.pattern != TLP_PAT_OFF |-> stat.pattern_ok == ok_exp)
      else $error("pattern legality wrong");
   a_tx_refused: assert property (
      (ctrl.pattern != TLP_PAT_OFF || stat.rev_loop_active) |-> !tx_ready)
      else $error("fabric word taken while refused");
   a_tx_first: assert property (tx_ready |=> ser_tx_bit == $past(tx_data[0]))
      else $error("first serial bit wrong");
   a_rx_quiet: assert property (rx_valid |=> s_quiet)
      else $error("received words too close");
   a_verify_clear: assert property (
      !ctrl.verify_en |=> !stat.prbs_error && !stat.prbs_locked)
      else $error("verifier not cleared");
   a_lock_hold: assert property (s_hold |=> stat.prbs_locked)
      else $error("verifier lock lost");
endmodule
bind tlp_channel tlp_channel_asserts tlp_channel_asserts_inst (
   .clk_sys(clk_sys), .rst(rst), .ctrl(ctrl), .tx_data(tx_data), .tx_ready(tx_ready),
   .rx_data(rx_data), .rx_valid(rx_valid), .stat(stat), .ser_tx_bit(ser_tx_bit),
   .ser_rx_bit(ser_rx_bit), .rx_buf_en(rx_buf_en));

// ---- tlp_partner.sv ----
// Remote link partner that sends 10-bit words into the receive pin
`timescale 1ns/10ps
module tlp_partner (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic [9:0] word,
   output logic            take,
   output logic            ser_rx_bit
);
   logic [9:0] sh;
   logic [9:0] next_sh;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic       tog;
   // Bit 0 first; a new word may follow the last bit directly
   always_comb begin
      take = (cnt <= 4'h1);
      next_sh = sh >> 1;
      next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
      if (load && take) begin
         next_sh = word;
         next_cnt = 4'hA;
      end
   end
   always_ff @(posedge clk_sys) begin
      sh <= rst ? 10'h000 : next_sh;
      cnt <= rst ? 4'h0 : next_cnt;
      tog <= rst ? 1'b0 : !tog;
   end
   // Idle line toggles so a stale level never passes for data
   assign ser_rx_bit = (cnt != 4'h0) ? sh[0] : tog;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the channel test block
`timescale 1ns/10ps
module tb_top;
   import tlp_pkg::*;
   logic            clk_sys;
   logic            rst;
   tlp_ctrl_t       ctrl;
   logic [WMAX-1:0] tx_data;
   logic            tx_ready;
   logic [WMAX-1:0] rx_data;
   logic            rx_valid;
   tlp_stat_t       stat;
   logic            ser_tx_bit;
   logic            ser_rx_bit;
   logic            rx_buf_en;
   logic            load;
   logic [9:0]      word;
   logic            take;
   logic [1:0]      idx = 2'h0;
   logic [9:0]      win;
   logic            seen;
   logic            got;
   logic [9:0]      first;
   int              num_errors;
   int              check_count;
   logic [9:0]      tbl [4] = '{10'h17C, 10'h2A5, 10'h0F0, 10'h333};
   tlp_channel #(.DATA_ALIGN(16'h017C), .DATA_ALIGN_LEN(5'h0A)) tlp_channel_inst (
      .clk_sys(clk_sys), .rst(rst), .ctrl(ctrl), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .stat(stat), .ser_tx_bit(ser_tx_bit),
      .ser_rx_bit(ser_rx_bit), .rx_buf_en(rx_buf_en));
   tlp_partner tlp_partner_inst (.clk_sys(clk_sys), .rst(rst), .load(load), .word(word),
      .take(take), .ser_rx_bit(ser_rx_bit));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = !clk_sys;
   end
   // Fabric words: alignment first, then data
   assign tx_data = tbl[idx];
   // Word source, transmit pin window, first received word
   always @(posedge clk_sys) begin
      win <= {ser_tx_bit, win[9:1]};
      if (rst) begin
         idx <= 2'h0;
         seen <= 1'b0;
         got <= 1'b0;
      end else begin
         if (tx_ready && idx != 2'h3)
            idx <= idx + 2'h1;
         if (win === 10'h2A5)
            seen <= 1'b1;
         if (rx_valid && !got) begin
            got <= 1'b1;
            first <= rx_data;
         end
      end
   end
   function automatic tlp_ctrl_t mk(logic p, logic l, logic s, tlp_pat_t t, logic w, logic v);
      mk = '{p, l, TLP_PWR_P0, s, t, w, v};
   endfunction
   task check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task stop_test;
      $display("Checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task do_reset(input tlp_ctrl_t c);
      @(posedge clk_sys);
      rst <= 1'b1;
      ctrl <= c;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
   endtask
   task wait_rx(output logic [9:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (rx_valid !== 1'b1 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      d = rx_data;
      check(rx_valid === 1'b1, "no word");
      @(negedge clk_sys);
   endtask
   task send(input logic [9:0] w);
      load <= 1'b1;
      word <= w;
      @(negedge clk_sys);
      while (take !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
   endtask
   task t_hf(input logic w);
      logic prev;
      do_reset(mk(0, 0, 0, TLP_PAT_HF, w, 0));
      repeat (30) @(negedge clk_sys);
      prev = ser_tx_bit;
      repeat (20) begin
         @(negedge clk_sys);
         check(ser_tx_bit === !prev && tx_ready === 1'b0, "hf bits");
         prev = ser_tx_bit;
      end
      check(stat.pattern_ok === 1'b1, "hf width");
   endtask
   task t_ser_loop;
      logic [9:0] d;
      do_reset(mk(0, 0, 1, TLP_PAT_OFF, 1, 0));
      wait_rx(d);
      check(d === 10'h2A5, "loop word 1");
      wait_rx(d);
      check(d === 10'h0F0, "loop word 2");
      check(rx_buf_en === 1'b0, "buffer on");
      check(stat.aligned === 1'b1 && stat.ser_loop_active === 1'b1 && stat.rev_loop_active === 1'b0, "loop status");
   endtask
   task t_rev_loop;
      int n;
      do_reset(mk(1, 1, 0, TLP_PAT_OFF, 1, 0));
      send(10'h17C);
      send(10'h2A5);
      send(10'h0F0);
      load <= 1'b0;
      for (n = 0; n < 60 && seen !== 1'b1; n++)
         @(negedge clk_sys);
      check(got === 1'b1 && first === 10'h2A5, "rev rx word");
      check(seen === 1'b1, "rev resend");
      @(posedge clk_sys);
      ctrl.power_state <= 2'h2;
      ctrl.serial_loop <= 1'b1;
      @(negedge clk_sys);
      check(stat.rev_loop_active === 1'b0 && stat.ser_loop_active === 1'b0 && rx_buf_en === 1'b1, "gate off");
   endtask
   task t_prbs(input tlp_pat_t t, input int x, input int k, input logic w);
      logic [99:0] b;
      logic ok1;
      logic ok2;
      int n;
      do_reset(mk(0, 0, 1, t, !w, 0));
      @(negedge clk_sys);
      check(stat.pattern_ok === 1'b0, "bad width");
      @(posedge clk_sys);
      ctrl <= mk(0, 0, 1, t, w, 1);
      for (n = 0; n < 600 && stat.prbs_locked !== 1'b1; n++)
         @(negedge clk_sys);
      for (n = 0; n < 100; n++) begin
         @(negedge clk_sys);
         b[n] = ser_tx_bit;
      end
      ok1 = 1'b1;
      ok2 = 1'b1;
      for (n = 30; n < 100; n++) begin
         ok1 &= (b[n] === (b[n-x] ^ b[n-k]));
         ok2 &= (b[n] === (b[n-x] ^ b[n-x+k]));
      end
      check(stat.prbs_locked === 1'b1 && (|b) && (ok1 || ok2), "prbs");
      check(stat.prbs_error === 1'b0, "prbs error");
      @(posedge clk_sys);
      ctrl.serial_loop <= 1'b0;
      repeat (60) @(negedge clk_sys);
      check(stat.prbs_error === 1'b1 && rx_buf_en === 1'b1, "pin error");
      @(posedge clk_sys);
      ctrl.verify_en <= 1'b0;
      repeat (2) @(negedge clk_sys);
      check(stat.prbs_locked === 1'b0 && stat.prbs_error === 1'b0, "clear");
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      ctrl = '0;
      load = 1'b0;
      word = '0;
      num_errors = 0;
      check_count = 0;
      t_hf(1'b0);
      t_hf(1'b1);
      t_ser_loop();
      t_rev_loop();
      t_prbs(TLP_PAT_PRBS7, 7, 6, 1'b0);
      t_prbs(TLP_PAT_PRBS8, 8, 7, 1'b0);
      t_prbs(TLP_PAT_PRBS10, 10, 7, 1'b1);
      t_prbs(TLP_PAT_PRBS23, 23, 18, 1'b0);
      stop_test();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      stop_test();
   end
endmodule
